// *** core/usu_pkg.sv ***
// package: register map, unit codes and result carriers for unit scaling
`default_nettype none
package usu_pkg;
	// ====================================================================
	// register offsets
	localparam logic [15:0] OFS_POS_UNIT = 16'h60a8;
	localparam logic [15:0] OFS_SPD_UNIT = 16'h60a9;
	localparam logic [15:0] OFS_VL_UNIT = 16'h604c;
	localparam logic [15:0] OFS_RATIO_BASE = 16'h6200;
	localparam logic [15:0] OFS_POLE_PAIRS = 16'h6210;
	localparam logic [15:0] OFS_MOTOR_3PH = 16'h6211;
	localparam logic [15:0] OFS_STATUS = 16'h6212;
	// ratio slots: numerator at base+2k, denominator at base+2k+1
	localparam int NUM_RATIO = 6;
	localparam int R_ENC = 0;
	localparam int R_GEAR = 1;
	localparam int R_FEED = 2;
	localparam int R_VEL = 3;
	localparam int R_ACC = 4;
	localparam int R_JERK = 5;
	// ====================================================================
	// reset values and field layout
	localparam logic [31:0] RST_POS_UNIT = 32'hff410000;
	localparam logic [31:0] RST_SPD_UNIT = 32'h00b44700;
	localparam logic [31:0] RST_RATIO = 32'h00000001;
	localparam logic [7:0] RST_POLE_PAIRS = 8'h32;
	localparam int EXP_LSB = 24;
	localparam int UNIT_LSB = 16;
	localparam int TIME_LSB = 8;
	localparam logic [31:0] POS_WR_MASK = 32'hffff0000;
	localparam logic [31:0] SPD_WR_MASK = 32'hffffff00;
	localparam logic signed [7:0] EXP_MIN = -8'sd6;
	localparam logic signed [7:0] EXP_MAX = 8'sd6;
	// ====================================================================
	// position unit codes
	localparam logic [7:0] U_DIMLESS = 8'h00;
	localparam logic [7:0] U_METER = 8'h01;
	localparam logic [7:0] U_INCH = 8'hc1;
	localparam logic [7:0] U_FOOT = 8'hc2;
	localparam logic [7:0] U_GRAD = 8'h40;
	localparam logic [7:0] U_RADIAN = 8'h10;
	localparam logic [7:0] U_DEGREE = 8'h41;
	localparam logic [7:0] U_ARCMIN = 8'h42;
	localparam logic [7:0] U_ARCSEC = 8'h43;
	localparam logic [7:0] U_REV = 8'hb4;
	localparam logic [7:0] U_ENC_INC = 8'hb5;
	localparam logic [7:0] U_STEP = 8'hac;
	localparam logic [7:0] U_ELEC_POLE = 8'hc0;
	// time unit codes
	localparam logic [7:0] T_SECOND = 8'h03;
	localparam logic [7:0] T_MINUTE = 8'h47;
	localparam logic [7:0] T_HOUR = 8'h48;
	localparam logic [7:0] T_DAY = 8'h49;
	localparam logic [7:0] T_YEAR = 8'h4a;
	// ====================================================================
	// scale constants
	localparam logic [15:0] LEN_DEN_INCH = 16'd10000;
	localparam logic [15:0] LEN_NUM_INCH = 16'd254;
	localparam logic [15:0] LEN_NUM_FOOT = 16'd3048;
	localparam logic [15:0] LEN_UNITY = 16'd1;
	localparam logic [31:0] PER_REV_GRAD = 32'd400;
	localparam logic [31:0] PER_REV_DEG = 32'd360;
	localparam logic [31:0] PER_REV_AMIN = 32'd21600;
	localparam logic [31:0] PER_REV_ASEC = 32'd1296000;
	localparam logic [31:0] PER_REV_ONE = 32'd1;
	localparam logic [31:0] SEC_MINUTE = 32'd60;
	localparam logic [31:0] SEC_HOUR = 32'd3600;
	localparam logic [31:0] SEC_DAY = 32'd86400;
	localparam logic [31:0] SEC_YEAR = 32'd31557600;
	localparam logic [3:0] STEPS_2PH = 4'd4;
	localparam logic [3:0] STEPS_3PH = 4'd6;
	// ====================================================================
	// carriers
	typedef enum logic [2:0] {
		USU_CLS_BAD = 3'b000,
		USU_CLS_LEN = 3'b001,
		USU_CLS_ANG = 3'b010,
		USU_CLS_ENC = 3'b011,
		USU_CLS_STEP = 3'b100,
		USU_CLS_POLE = 3'b101
	} usu_cls_t;
	typedef struct packed {
		usu_cls_t cls;
		logic apply_gear;
		logic apply_feed;
		logic is_radian;
		logic exp_ok;
		logic signed [7:0] exp;
		logic [31:0] per_rev;
		logic [15:0] len_num;
		logic [15:0] len_den;
	} usu_pos_info_t;
	typedef struct packed {
		logic [7:0] pos_code;
		logic time_ok;
		logic [31:0] time_sec;
		logic exp_ok;
		logic signed [7:0] exp;
	} usu_spd_info_t;
endpackage
`default_nettype wire

// *** core/usu_ratio_div.sv ***
// module: sequential fixed-point divider giving num/den in q16.16
`default_nettype none
module usu_ratio_div
	import usu_pkg::*;
#(
	parameter int W = 32,
	parameter int F = 16
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [W-1:0] num,
	input wire logic [W-1:0] den,
	output logic busy,
	output logic done,
	output logic div_zero,
	output logic overflow,
	output logic [W-1:0] quo
);
	localparam int N = W + F;
	localparam int CW = $clog2(N + 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(N);
	localparam logic [CW-1:0] CNT_ONE = CW'(1);

	logic [N-1:0] q_reg;
	logic [W:0] r_reg;
	logic [W-1:0] d_reg;
	logic [CW-1:0] cnt_reg;
	logic [W:0] shifted;
	logic [W:0] trial;

	// ====================================================================
	// restoring step
	assign shifted = {r_reg[W-1:0], q_reg[N-1]};
	assign trial = shifted - {1'b0, d_reg};
	assign quo = q_reg[W-1:0];
	assign overflow = |q_reg[N-1:W];

	// iteration, one quotient bit a cycle
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q_reg <= '0;
			r_reg <= '0;
			d_reg <= '0;
			cnt_reg <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			div_zero <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				div_zero <= (den == '0);
				q_reg <= {num, {F{1'b0}}};
				r_reg <= '0;
				d_reg <= den;
				cnt_reg <= CNT_FULL;
				busy <= (den != '0);
				done <= (den == '0); // zero divisor ends at once
			end
			else if (busy)
			begin
				if (!trial[W])
				begin
					r_reg <= trial;
					q_reg <= {q_reg[N-2:0], 1'b1};
				end
				else
				begin
					r_reg <= shifted;
					q_reg <= {q_reg[N-2:0], 1'b0};
				end
				cnt_reg <= cnt_reg - CNT_ONE;
				if (cnt_reg == CNT_ONE)
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** core/usu_unit_scale.sv ***
// module: user unit decode, ratio scaling and held-off configuration
// Function
// - writes while operation enabled apply only once that state is left
// - meter 01h, inch c1h, foot c2h, dimensionless 00h; gear and feed
// - angular codes 40h,10h,41h,42h,43h,b4h use gear but not feed
// - encoder b5h, step ach: no gear or feed; encoder rev = resolution ratio, step rev = pole pairs * 4 or 6
// - electrical pole c0h is one rev over pole pairs, no gear or feed
// - time codes 03h,47h,48h,49h,4ah decode to seconds, year 365.25 days
// - exponent byte is signed, valid from -6 to +6
// - encoder resolution is increments over motor revolutions
// - gear ratio is motor revolutions over shaft revolutions
// - feed constant is feed over shaft revs, for length units only
// - position word: unit bits 23:16, exponent 31:24, low 16 bits zero
// - speed word: time 15:8, unit 23:16, exponent 31:24, low byte 0
// - velocity mode speed unit defaults to rpm, set only via its own word
// - velocity factor is numerator over denominator, scales speed unit
// - acceleration unit is speed per second times its factor ratio
// - jerk unit is acceleration per second times its factor ratio
`default_nettype none
module usu_unit_scale
	import usu_pkg::*;
#(
	parameter int DW = 32
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [15:0] reg_addr,
	input wire logic [DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DW-1:0] reg_rdata,
	input wire logic op_enabled,
	input wire logic vel_mode,
	output usu_pos_info_t pos_info,
	output usu_spd_info_t spd_info,
	output logic [NUM_RATIO-1:0][DW-1:0] ratio_q,
	output logic [NUM_RATIO-1:0] ratio_valid,
	output logic [NUM_RATIO-1:0] ratio_fault,
	output logic cfg_pending
);
	// ====================================================================
	// storage
	logic [DW-1:0] pos_unit_reg;
	logic [DW-1:0] spd_unit_reg;
	logic [DW-1:0] vl_unit_reg;
	logic [NUM_RATIO-1:0][DW-1:0] num_reg;
	logic [NUM_RATIO-1:0][DW-1:0] den_reg;
	logic [7:0] pole_pairs_reg;
	logic motor_3ph_reg;
	logic [DW-1:0] act_pos_reg;
	logic [DW-1:0] act_spd_reg;
	logic [DW-1:0] act_vl_reg;
	logic [NUM_RATIO-1:0][DW-1:0] act_num_reg;
	logic [NUM_RATIO-1:0][DW-1:0] act_den_reg;
	logic [7:0] act_pole_reg;
	logic act_3ph_reg;
	logic dirty_reg;
	logic commit_reg;
	logic [NUM_RATIO-1:0] div_busy;
	logic [NUM_RATIO-1:0] div_done;
	logic [NUM_RATIO-1:0] div_zero;
	logic [NUM_RATIO-1:0] div_ovf;
	logic [NUM_RATIO-1:0][DW-1:0] div_quo;
	logic commit_now;
	logic [15:0] ratio_ofs;
	logic [3:0] ratio_idx;
	logic ratio_hit;
	usu_pos_info_t pos_next;
	usu_spd_info_t spd_next;
	logic [DW-1:0] spd_word;
	logic [7:0] pcode;
	logic [7:0] tcode;
	logic signed [7:0] pexp;
	logic signed [7:0] sexp;

	// ====================================================================
	// address decode for ratio slots
	assign ratio_ofs = reg_addr - OFS_RATIO_BASE;
	assign ratio_idx = ratio_ofs[4:1];
	assign ratio_hit = (reg_addr >= OFS_RATIO_BASE)
		&& (ratio_ofs < 16'(2 * NUM_RATIO));

	// software writes land in the shadow copy only
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pos_unit_reg <= RST_POS_UNIT;
			spd_unit_reg <= RST_SPD_UNIT;
			vl_unit_reg <= RST_SPD_UNIT; // rpm preset
			num_reg <= {NUM_RATIO{RST_RATIO}};
			den_reg <= {NUM_RATIO{RST_RATIO}};
			pole_pairs_reg <= RST_POLE_PAIRS;
			motor_3ph_reg <= 1'b0;
		end
		else if (reg_wr)
		begin
			if (reg_addr == OFS_POS_UNIT)
				pos_unit_reg <= reg_wdata & POS_WR_MASK;
			else if (reg_addr == OFS_SPD_UNIT)
				spd_unit_reg <= reg_wdata & SPD_WR_MASK;
			else if (reg_addr == OFS_VL_UNIT)
				vl_unit_reg <= reg_wdata & SPD_WR_MASK;
			else if (reg_addr == OFS_POLE_PAIRS)
				pole_pairs_reg <= reg_wdata[7:0];
			else if (reg_addr == OFS_MOTOR_3PH)
				motor_3ph_reg <= reg_wdata[0];
			else if (ratio_hit && !ratio_ofs[0])
				num_reg[ratio_idx] <= reg_wdata;
			else if (ratio_hit)
				den_reg[ratio_idx] <= reg_wdata;
		end
	end

	// ====================================================================
	// hold-off: changes wait until operation enabled is left
	assign commit_now = dirty_reg && !op_enabled;

	// pending flag; a write in the commit cycle keeps it set
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			dirty_reg <= 1'b1;
		else if (reg_wr)
			dirty_reg <= 1'b1;
		else if (commit_now)
			dirty_reg <= 1'b0;
	end

	// copy shadow into the working set
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			act_pos_reg <= RST_POS_UNIT;
			act_spd_reg <= RST_SPD_UNIT;
			act_vl_reg <= RST_SPD_UNIT;
			act_num_reg <= {NUM_RATIO{RST_RATIO}};
			act_den_reg <= {NUM_RATIO{RST_RATIO}};
			act_pole_reg <= RST_POLE_PAIRS;
			act_3ph_reg <= 1'b0;
			commit_reg <= 1'b0;
		end
		else
		begin
			commit_reg <= commit_now;
			if (commit_now)
			begin
				act_pos_reg <= pos_unit_reg;
				act_spd_reg <= spd_unit_reg;
				act_vl_reg <= vl_unit_reg;
				act_num_reg <= num_reg;
				act_den_reg <= den_reg;
				act_pole_reg <= pole_pairs_reg;
				act_3ph_reg <= motor_3ph_reg;
			end
		end
	end

	// ====================================================================
	// field extraction
	assign pcode = act_pos_reg[UNIT_LSB +: 8];
	assign pexp = act_pos_reg[EXP_LSB +: 8];
	// velocity mode ignores the general speed word
	assign spd_word = vel_mode ? act_vl_reg : act_spd_reg;
	assign tcode = spd_word[TIME_LSB +: 8];
	assign sexp = spd_word[EXP_LSB +: 8];

	// position unit class, gear and feed use, units per revolution
	always_comb
	begin
		pos_next = '0;
		pos_next.cls = USU_CLS_BAD;
		pos_next.len_num = LEN_UNITY;
		pos_next.len_den = LEN_UNITY;
		pos_next.exp = pexp;
		pos_next.exp_ok = (pexp >= EXP_MIN) && (pexp <= EXP_MAX);
		case (pcode)
			U_METER, U_DIMLESS:
			begin
				pos_next.cls = USU_CLS_LEN;
				pos_next.apply_gear = 1'b1;
				pos_next.apply_feed = 1'b1;
			end
			U_INCH, U_FOOT:
			begin
				pos_next.cls = USU_CLS_LEN;
				pos_next.apply_gear = 1'b1;
				pos_next.apply_feed = 1'b1;
				pos_next.len_num = (pcode == U_INCH) ? LEN_NUM_INCH
					: LEN_NUM_FOOT;
				pos_next.len_den = LEN_DEN_INCH;
			end
			U_GRAD, U_RADIAN, U_DEGREE, U_ARCMIN, U_ARCSEC, U_REV:
			begin
				pos_next.cls = USU_CLS_ANG;
				pos_next.apply_gear = 1'b1;
				pos_next.is_radian = (pcode == U_RADIAN);
				case (pcode)
					U_GRAD: pos_next.per_rev = PER_REV_GRAD;
					U_DEGREE: pos_next.per_rev = PER_REV_DEG;
					U_ARCMIN: pos_next.per_rev = PER_REV_AMIN;
					U_ARCSEC: pos_next.per_rev = PER_REV_ASEC;
					U_REV: pos_next.per_rev = PER_REV_ONE;
					default: pos_next.per_rev = '0;
				endcase
			end
			U_ENC_INC:
			begin
				pos_next.cls = USU_CLS_ENC;
				pos_next.per_rev = ratio_q[R_ENC];
			end
			U_STEP:
			begin
				pos_next.cls = USU_CLS_STEP;
				pos_next.per_rev = 32'(act_pole_reg)
					* 32'(act_3ph_reg ? STEPS_3PH : STEPS_2PH);
			end
			U_ELEC_POLE:
			begin
				pos_next.cls = USU_CLS_POLE;
				pos_next.per_rev = 32'(act_pole_reg);
			end
			default:
				pos_next.cls = USU_CLS_BAD;
		endcase
	end

	// time unit in seconds
	always_comb
	begin
		spd_next = '0;
		spd_next.pos_code = spd_word[UNIT_LSB +: 8];
		spd_next.exp = sexp;
		spd_next.exp_ok = (sexp >= EXP_MIN) && (sexp <= EXP_MAX);
		spd_next.time_ok = 1'b1;
		case (tcode)
			T_SECOND: spd_next.time_sec = PER_REV_ONE;
			T_MINUTE: spd_next.time_sec = SEC_MINUTE;
			T_HOUR: spd_next.time_sec = SEC_HOUR;
			T_DAY: spd_next.time_sec = SEC_DAY;
			T_YEAR: spd_next.time_sec = SEC_YEAR;
			default: spd_next.time_ok = 1'b0;
		endcase
	end

	// registered decode results
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pos_info <= '0;
			spd_info <= '0;
		end
		else
		begin
			pos_info <= pos_next;
			spd_info <= spd_next;
		end
	end

	// ====================================================================
	// one divider per ratio, started after each commit
	genvar gi;
	generate
		for (gi = 0; gi < NUM_RATIO; gi++)
		begin : g_ratio
			// enc gear feed vel acc jerk
			usu_ratio_div #(.W(DW), .F(16)) u_div (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.start(commit_reg),
				.num(act_num_reg[gi]),
				.den(act_den_reg[gi]),
				.busy(div_busy[gi]),
				.done(div_done[gi]),
				.div_zero(div_zero[gi]),
				.overflow(div_ovf[gi]),
				.quo(div_quo[gi])
			);
		end
	endgenerate

	// capture quotients; valid drops while a new one runs
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ratio_q <= '0;
			ratio_valid <= '0;
			ratio_fault <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_RATIO; i++)
			begin
				if (commit_reg)
					ratio_valid[i] <= 1'b0;
				else if (div_done[i])
				begin
					ratio_q[i] <= div_quo[i];
					ratio_valid[i] <= !(div_zero[i] || div_ovf[i]);
					ratio_fault[i] <= div_zero[i] || div_ovf[i];
				end
			end
		end
	end

	// ====================================================================
	// read port, data one cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_rdata <= '0;
			cfg_pending <= 1'b0;
		end
		else
		begin
			cfg_pending <= dirty_reg && op_enabled;
			reg_rdata <= '0;
			if (reg_rd)
			begin
				if (reg_addr == OFS_POS_UNIT)
					reg_rdata <= pos_unit_reg;
				else if (reg_addr == OFS_SPD_UNIT)
					reg_rdata <= spd_unit_reg;
				else if (reg_addr == OFS_VL_UNIT)
					reg_rdata <= vl_unit_reg;
				else if (reg_addr == OFS_POLE_PAIRS)
					reg_rdata <= 32'(pole_pairs_reg);
				else if (reg_addr == OFS_MOTOR_3PH)
					reg_rdata <= 32'(motor_3ph_reg);
				else if (reg_addr == OFS_STATUS)
					reg_rdata <= 32'({dirty_reg, |div_busy,
						ratio_fault, ratio_valid});
				else if (ratio_hit && !ratio_ofs[0])
					reg_rdata <= num_reg[ratio_idx];
				else if (ratio_hit)
					reg_rdata <= den_reg[ratio_idx];
			end
		end
	end
endmodule
`default_nettype wire

// *** dv/usu_unit_scale_asserts.sv ***
// checker: port properties of the unit scaling block
`default_nettype none
module usu_unit_scale_asserts
	import usu_pkg::*;
#(
	parameter int DW = 32
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [15:0] reg_addr,
	input wire logic [DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DW-1:0] reg_rdata,
	input wire logic op_enabled,
	input wire logic vel_mode,
	input wire usu_pos_info_t pos_info,
	input wire usu_spd_info_t spd_info,
	input wire logic [NUM_RATIO-1:0][DW-1:0] ratio_q,
	input wire logic [NUM_RATIO-1:0] ratio_valid,
	input wire logic [NUM_RATIO-1:0] ratio_fault,
	input wire logic cfg_pending
);
	// ====================================================================
	// sequences
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_held;
		op_enabled ##1 op_enabled;
	endsequence
	sequence s_idle;
		(!op_enabled && !reg_wr) [*3];
	endsequence
	sequence s_op_wr;
		reg_wr && op_enabled && reg_addr == OFS_POS_UNIT;
	endsequence
	// ====================================================================
	// properties
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
		else $error("read data not zero outside a read");
	a_pos_rsvd: assert property (reg_rd && reg_addr == OFS_POS_UNIT
		|=> reg_rdata[15:0] == 16'h0000)
		else $error("position word low half not zero");
	a_spd_rsvd: assert property (reg_rd && (reg_addr == OFS_SPD_UNIT
		|| reg_addr == OFS_VL_UNIT) |=> reg_rdata[7:0] == 8'h00)
		else $error("speed word low byte not zero");
	a_pend_set: assert property (s_op_wr ##1 op_enabled [*3]
		|-> cfg_pending)
		else $error("held write not flagged pending");
	a_pend_clr: assert property (s_idle |-> !cfg_pending)
		else $error("pending stays set while disabled");
	a_held_stable: assert property (s_held |=> $stable({pos_info.cls,
		pos_info.apply_gear, pos_info.apply_feed, pos_info.exp}))
		else $error("position decode moved while enabled");
	a_exp_ok: assert property ($past(rst_n, 2) |-> pos_info.exp_ok ==
		($signed(pos_info.exp) >= EXP_MIN && $signed(pos_info.exp) <= EXP_MAX))
		else $error("position exponent range flag wrong");
	a_spd_exp: assert property ($past(rst_n, 2) |-> spd_info.exp_ok ==
		($signed(spd_info.exp) >= EXP_MIN && $signed(spd_info.exp) <= EXP_MAX))
		else $error("speed exponent range flag wrong");
	a_feed_len: assert property (pos_info.cls != USU_CLS_BAD
		|-> pos_info.apply_feed == (pos_info.cls == USU_CLS_LEN))
		else $error("feed flag wrong for unit class");
	a_gear_cls: assert property (pos_info.cls != USU_CLS_BAD
		|-> pos_info.apply_gear == (pos_info.cls inside {USU_CLS_LEN,
		USU_CLS_ANG}))
		else $error("gear flag wrong for unit class");
	a_radian_ang: assert property (pos_info.is_radian
		|-> pos_info.cls == USU_CLS_ANG && pos_info.per_rev == '0)
		else $error("radian decode wrong");
	a_fault_excl: assert property ((ratio_valid & ratio_fault) == '0)
		else $error("ratio valid and fault together");
endmodule

// attach to every instance of the block
bind usu_unit_scale usu_unit_scale_asserts #(.DW(DW)) u_chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .op_enabled(op_enabled), .vel_mode(vel_mode),
	.pos_info(pos_info), .spd_info(spd_info), .ratio_q(ratio_q),
	.ratio_valid(ratio_valid), .ratio_fault(ratio_fault),
	.cfg_pending(cfg_pending));
`default_nettype wire

// *** dv/tb.sv ***
// testbench: register, decode and ratio scenarios for unit scaling
`default_nettype none
`define CHK(a, b) \
	begin \
		cmp_count++; \
		if ((a) !== (b)) \
		begin \
			err_count++; \
			$display("ERROR %0t: got %h exp %h", $time, a, b); \
		end \
	end
module tb
	import usu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic op_enabled = 1'b0;
	logic vel_mode = 1'b0;
	logic [31:0] reg_rdata;
	usu_pos_info_t pos_info;
	usu_spd_info_t spd_info;
	logic [NUM_RATIO-1:0][31:0] ratio_q;
	logic [NUM_RATIO-1:0] ratio_valid;
	logic [NUM_RATIO-1:0] ratio_fault;
	logic cfg_pending;
	int err_count = 0;
	int cmp_count = 0;
	usu_unit_scale DUT (.ref_clk(ref_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_enabled(op_enabled),
		.vel_mode(vel_mode), .pos_info(pos_info), .spd_info(spd_info),
		.ratio_q(ratio_q), .ratio_valid(ratio_valid),
		.ratio_fault(ratio_fault), .cfg_pending(cfg_pending));
	// ====================================================================
	// clock and bus tasks
	initial
	begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, e)
	endtask
	task automatic settle();
		repeat (4) @(posedge ref_clk);
		#1;
	endtask
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ====================================================================
	// scenarios
	task automatic t_reset();
		rdchk(OFS_POS_UNIT, 32'hff410000);
		rdchk(OFS_SPD_UNIT, 32'h00b44700);
		`CHK(pos_info.cls, USU_CLS_ANG)
		`CHK(pos_info.per_rev, PER_REV_DEG)
		`CHK(pos_info.exp, 8'hff)
		`CHK(spd_info.pos_code, U_REV)
		`CHK(spd_info.time_sec, SEC_MINUTE)
		wr(16'h1234, 32'hffffffff);
		rdchk(16'h1234, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_pos();
		logic [7:0] pc[14] = '{U_METER, U_INCH, U_FOOT, U_DIMLESS, U_GRAD,
			U_RADIAN, U_DEGREE, U_ARCMIN, U_ARCSEC, U_REV, U_ENC_INC, U_STEP,
			U_ELEC_POLE, 8'h55};
		usu_cls_t pk[14] = '{USU_CLS_LEN, USU_CLS_LEN, USU_CLS_LEN,
			USU_CLS_LEN, USU_CLS_ANG, USU_CLS_ANG, USU_CLS_ANG, USU_CLS_ANG,
			USU_CLS_ANG, USU_CLS_ANG, USU_CLS_ENC, USU_CLS_STEP, USU_CLS_POLE,
			USU_CLS_BAD};
		logic [31:0] pr[14] = '{32'h0, 32'h0, 32'h0, 32'h0, PER_REV_GRAD,
			32'h0, PER_REV_DEG, PER_REV_AMIN, PER_REV_ASEC, PER_REV_ONE,
			32'h0, 32'hc8, 32'h32, 32'h0};
		logic [7:0] ev[5] = '{8'h06, 8'hfa, 8'hff, 8'h07, 8'hf9};
		for (int i = 0; i < 14; i++)
		begin
			wr(OFS_POS_UNIT, {8'h00, pc[i], 16'h0000});
			settle();
			`CHK(pos_info.cls, pk[i])
			if (pr[i] != 32'h0)
				`CHK(pos_info.per_rev, pr[i])
			`CHK(pos_info.is_radian, pc[i] == U_RADIAN)
			`CHK(pos_info.apply_feed, pk[i] == USU_CLS_LEN)
			if (pc[i] == U_INCH)
				`CHK(pos_info.len_num, LEN_NUM_INCH)
			if (pc[i] == U_INCH || pc[i] == U_FOOT)
				`CHK(pos_info.len_den, LEN_DEN_INCH)
			if (pc[i] == U_FOOT)
				`CHK(pos_info.len_num, LEN_NUM_FOOT)
		end
		wr(OFS_MOTOR_3PH, 32'h1);
		wr(OFS_POLE_PAIRS, 32'h0a);
		wr(OFS_POS_UNIT, {8'h00, U_STEP, 16'h0000});
		settle();
		`CHK(pos_info.per_rev, 32'h3c)
		for (int i = 0; i < 5; i++)
		begin
			wr(OFS_POS_UNIT, {ev[i], U_DEGREE, 16'hffff});
			settle();
			`CHK({pos_info.exp, pos_info.exp_ok}, {ev[i], i < 3})
		end
		rdchk(OFS_POS_UNIT, 32'hf9410000);
		$display("test position units done");
	endtask
	task automatic t_spd();
		logic [7:0] tc[6] = '{T_SECOND, T_MINUTE, T_HOUR, T_DAY, T_YEAR,
			8'h11};
		logic [31:0] ts[6] = '{32'h1, SEC_MINUTE, SEC_HOUR, SEC_DAY,
			SEC_YEAR, 32'h0};
		for (int i = 0; i < 6; i++)
		begin
			wr(OFS_SPD_UNIT, {8'hfd, U_METER, tc[i], 8'hff});
			settle();
			`CHK(spd_info.time_ok, i < 5)
			if (i < 5)
				`CHK(spd_info.time_sec, ts[i])
			`CHK({spd_info.pos_code, spd_info.exp}, {U_METER, 8'hfd})
			`CHK(spd_info.exp_ok, 1'b1)
		end
		rdchk(OFS_SPD_UNIT, 32'hfd011100);
		@(posedge ref_clk);
		vel_mode <= 1'b1;
		settle();
		`CHK({spd_info.pos_code, spd_info.time_sec}, {U_REV, SEC_MINUTE})
		wr(OFS_VL_UNIT, {8'h00, U_DEGREE, T_SECOND, 8'h00});
		settle();
		`CHK({spd_info.pos_code, spd_info.time_sec}, {U_DEGREE, 32'h1})
		@(posedge ref_clk);
		vel_mode <= 1'b0;
		settle();
		`CHK(spd_info.pos_code, U_METER)
		$display("test speed units done");
	endtask
	task automatic t_hold();
		@(posedge ref_clk);
		op_enabled <= 1'b1;
		wr(OFS_POS_UNIT, {8'h00, U_METER, 16'h0000});
		repeat (6) @(posedge ref_clk);
		#1 `CHK({pos_info.cls, cfg_pending}, {USU_CLS_ANG, 1'b1})
		rdchk(OFS_POS_UNIT, 32'h00010000);
		@(posedge ref_clk);
		op_enabled <= 1'b0;
		settle();
		`CHK({pos_info.cls, cfg_pending}, {USU_CLS_LEN, 1'b0})
		$display("test hold-off done");
	endtask
	task automatic wait_ratio();
		int n;
		n = 0;
		settle();
		while ((ratio_valid | ratio_fault) !== 6'h3f && n < 300)
		begin
			@(posedge ref_clk);
			n++;
		end
		#1;
		if (n == 300)
		begin
			err_count++;
			wrap_up();
		end
	endtask
	task automatic t_ratio();
		for (int k = 0; k < NUM_RATIO; k++)
		begin
			wr(OFS_RATIO_BASE + 16'(2 * k), 32'(k + 1) * 32'h3);
			wr(OFS_RATIO_BASE + 16'(2 * k + 1), 32'h2);
		end
		wait_ratio();
		`CHK(ratio_valid, 6'h3f)
		for (int k = 0; k < NUM_RATIO; k++)
			`CHK(ratio_q[k], 32'(k + 1) * 32'h18000)
		wr(OFS_RATIO_BASE + 16'h3, 32'h0);
		wait_ratio();
		`CHK({ratio_fault[R_GEAR], ratio_valid[R_GEAR]}, 2'b10)
		$display("test ratios done");
	endtask
	// ====================================================================
	// main sequence
	initial
	begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		settle();
		t_reset();
		t_pos();
		t_spd();
		t_hold();
		t_ratio();
		wrap_up();
	end
endmodule
`default_nettype wire
